// *** src/host_port_dev.sv ***
// Purpose: Device end of the dual-style host bus port.
// Assumes: Pins arrive from outside the clock domain.
// Notes: A write to address 0 loads the holding register from the bus.
// Notes: A write to 1 or 2 moves the holding word into that target.
`timescale 1ns/10ps
`default_nettype none
`include "host_port_cfg.svh"
module host_port_dev #(
	parameter int IRQ_CNT_W = 16
) (
	input  wire logic                 clk_i,
	input  wire logic                 reset_i,
	host_port_if.device               pins,
	input  wire host_port_pkg::word_t sample_i,
	input  wire logic                 sample_valid_i,
	input  wire logic                 word_start_i,
	input  wire logic                 frame_start_i,
	output logic [15:0]               mark_cfg_o,
	output logic [15:0]               irq_len_o
);
	import host_port_pkg::*;

	// The pulse counter loads from a sixteen-bit register, so no wider width helps.
	// A width outside this range cannot be served, so elaboration stops.
	if (IRQ_CNT_W < 1 || IRQ_CNT_W > 16) begin : gen_bad_width
		$error("IRQ_CNT_W must be 1 to 16");
	end

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers.

	logic [15:0] data_s1_ff;
	logic [15:0] data_s2_ff;
	logic [1:0]  addr_s1_ff;
	logic [1:0]  addr_s2_ff;
	logic [3:0]  ctl_s1_ff;
	logic [3:0]  ctl_s2_ff;
	logic        wr_n_d_ff;

	// Two flops on every pin; the address MSB is never sampled.
	always_ff @(posedge clk_i) begin
		data_s1_ff <= pins.data;
		data_s2_ff <= data_s1_ff;
		addr_s1_ff <= pins.addr[1:0];
		addr_s2_ff <= addr_s1_ff;
		ctl_s1_ff  <= {pins.style, pins.cs_n, pins.rd_n, pins.wr_n};
		ctl_s2_ff  <= ctl_s1_ff;
	end

	// The control pins travel as one group, so a host that moves them
	// together is seen moving them in the same clock; the decode below
	// relies on that when the style changes.
	wire style_w = ctl_s2_ff[3];
	wire cs_n_w  = ctl_s2_ff[2];
	wire rd_n_w  = ctl_s2_ff[1];
	wire wr_n_w  = ctl_s2_ff[0];

	// Edge history flop; reset high so a strobe already high at release never fires.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wr_n_d_ff <= 1'b1;
		end else begin
			wr_n_d_ff <= wr_n_w;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Strobe decode.

	// One rising edge of the synced strobe gives exactly one transfer.
	wire strobe_rise = wr_n_w & !wr_n_d_ff;
	// Strobe style writes only with chip select low.
	wire wr_sep      = !style_w & !cs_n_w & strobe_rise;
	// Data-strobe style writes when the select line asks for it. Chip
	// select is not looked at in this style; the select line alone gates it.
	wire wr_data_strobe    = style_w & !rd_n_w & strobe_rise;
	wire wr_go       = wr_sep | wr_data_strobe;
	// Strobe style reads while read and chip select are both low.
	wire rd_sep      = !style_w & !rd_n_w & !cs_n_w;
	// Data-strobe style reads while the strobe is low and select high.
	wire rd_data_strobe    = style_w & rd_n_w & !wr_n_w;
	wire rd_go       = rd_sep | rd_data_strobe;

	////////////////////////////////////////////////////////////////////
	// Holding and target registers.

	logic [15:0] hold_ff;
	logic [15:0] mark_cfg_ff;
	logic [15:0] irq_len_ff;
	logic [15:0] sample_ff;

	// Address 3 holds the sample word, so a write there is dropped; the
	// sample is only ever loaded from the sample side.
	wire to_hold = wr_go & (addr_s2_ff == `ADDR_HOLD);
	wire to_mark = wr_go & (addr_s2_ff == `ADDR_MARK_CFG);
	wire to_len  = wr_go & (addr_s2_ff == `ADDR_IRQ_LEN);

	// Address 0 takes the bus word; other targets take the holding word.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			hold_ff     <= 16'h0000;
			mark_cfg_ff <= `MARK_CFG_RST;
			irq_len_ff  <= `IRQ_LEN_RST;
		end else begin
			if (to_hold) begin
				hold_ff <= data_s2_ff;
			end
			if (to_mark) begin
				mark_cfg_ff <= hold_ff;
			end
			if (to_len) begin
				irq_len_ff <= hold_ff;
			end
		end
	end

	// Latest output sample, kept for readback; writes to it are dropped.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sample_ff <= 16'h0000;
		end else if (sample_valid_i) begin
			sample_ff <= sample_i;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read path.

	logic [15:0] rd_word;
	logic [15:0] dev_q_ff;
	logic        dev_oe_n_ff;

	always_comb begin
		case (addr_s2_ff)
			`ADDR_HOLD:     rd_word = hold_ff;
			`ADDR_MARK_CFG: rd_word = mark_cfg_ff;
			`ADDR_IRQ_LEN:  rd_word = irq_len_ff;
			`ADDR_SAMPLE:   rd_word = sample_ff;
			default:        rd_word = 16'h0000;
		endcase
	end

	// Drive only during a read; bit 15 of the word lands on line 15.
	// The bus turns three clocks after the strobes move (two sync flops and
	// this flop), so a host must keep its strobe low at least that long and
	// wait as long again before it drives the bus itself. The read word
	// follows the registers live while the read lasts.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			dev_q_ff    <= 16'h0000;
			dev_oe_n_ff <= 1'b1;
		end else begin
			dev_q_ff    <= rd_word;
			dev_oe_n_ff <= !rd_go;
		end
	end

	assign pins.dev_q    = dev_q_ff;
	assign pins.dev_oe_n = dev_oe_n_ff;

	////////////////////////////////////////////////////////////////////
	// Interrupt pulse and frame mark.

	logic [IRQ_CNT_W-1:0] irq_cnt_ff;
	logic                 irq_ff;
	logic                 mark_ff;

	// Either enabled position raises the mark; both may be enabled at once.
	wire word_hit  = mark_cfg_ff[`MARK_WORD_BIT] & word_start_i;
	wire frame_hit = mark_cfg_ff[`MARK_FRAME_BIT] & frame_start_i;
	wire mark_hit  = word_hit | frame_hit;
	// Polarity bit set means an active-high mark.
	wire mark_pol  = mark_cfg_ff[`MARK_POL_BIT];

	// A new sample restarts the count, so the pulse always runs its length.
	// A zero length gives no pulse; samples closer than the length merge
	// into one long pulse, which a host counting pulses must allow for.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			irq_cnt_ff <= '0;
			irq_ff     <= 1'b0;
		end else if (sample_valid_i) begin
			irq_cnt_ff <= irq_len_ff[IRQ_CNT_W-1:0];
			irq_ff     <= (irq_len_ff[IRQ_CNT_W-1:0] != '0);
		end else if (irq_cnt_ff > 1) begin
			irq_cnt_ff <= irq_cnt_ff - 1'b1;
		end else begin
			irq_cnt_ff <= '0;
			irq_ff     <= 1'b0;
		end
	end

	// Mark takes the active level on a chosen position, idle level otherwise.
	// Reset leaves it low, the idle level of the reset polarity.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			mark_ff <= 1'b0;
		end else begin
			mark_ff <= mark_hit ~^ mark_pol;
		end
	end

	assign pins.irq        = irq_ff;
	assign pins.frame_mark = mark_ff;
	assign mark_cfg_o      = mark_cfg_ff;
	assign irq_len_o       = irq_len_ff;
endmodule
`default_nettype wire

// *** src/host_port_cfg.svh ***
// Purpose: Constants of the dual-style host bus port.
// Assumes: One 250 MHz clock on both ends.
// Notes: Offsets, fields, reset values and timing counts.
// Notes on behaviour
// - Frame mark output, polarity and position configurable.
// - Sixteen-bit two-way data bus, bit 15 MSB.
// - Address MSB reserved, ignored by decode.
// - Write loads holding register or moves it on.
// - Strobe style: write on strobe rise, chip selected.
// - Strobe style: drive data while read, select low.
// - Data-strobe style, select low: write on strobe rise.
// - Data-strobe style, select high: drive data, strobe low.
// - Host sets select high to read, low to write.
// - Style pin defaults low when left undriven.
// - Host drives active-low chip select like address.
// - Interrupt held configurable cycles per new sample.
// - Output samples also readable over the host port.
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH
`define ADDR_HOLD       2'h0
`define ADDR_MARK_CFG   2'h1
`define ADDR_IRQ_LEN    2'h2
`define ADDR_SAMPLE     2'h3
`define MARK_POL_BIT    0
`define MARK_WORD_BIT   1
`define MARK_FRAME_BIT  2
`define MARK_CFG_RST    16'h0005
`define IRQ_LEN_RST     16'h0004
`define STROBE_NS       32
`define CLK_NS          4
`define STROBE_CYC      ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define GAP_CYC         4
`endif

// *** src/host_port_pkg.sv ***
// Purpose: Types shared by both ends of the host bus port.
// Assumes: Constants live in host_port_cfg.svh.
// Notes: Data word type and host sequencer states.
`default_nettype none
package host_port_pkg;
	typedef logic [15:0] word_t;
	typedef enum logic [1:0] {H_IDLE, H_STROBE, H_GAP} host_state_e;
endpackage
`default_nettype wire

// *** src/host_port_if.sv ***
// Purpose: Pin bundle between the device end and the host end.
// Assumes: Drivers give data plus active-low enables.
// Notes: The wire levels are resolved here, not in the ends.
`timescale 1ns/10ps
`default_nettype none
interface host_port_if;
	logic [15:0] dev_q;
	logic        dev_oe_n;
	logic [15:0] host_q;
	logic        host_oe_n;
	logic [15:0] data;
	logic [2:0]  addr;
	logic        cs_n;
	logic        wr_n;
	logic        rd_n;
	logic        style_q;
	logic        style_oe_n;
	logic        style;
	logic        irq;
	logic        frame_mark;

	// The bus settles to whichever end enables; an idle bus reads zero.
	assign data = !dev_oe_n ? dev_q : (!host_oe_n ? host_q : 16'h0000);
	// An undriven style pin is pulled low, selecting strobe style.
	assign style = !style_oe_n & style_q;

	modport device (output dev_q, dev_oe_n, irq, frame_mark,
		input data, addr, cs_n, wr_n, rd_n, style);
	modport host (output host_q, host_oe_n, addr, cs_n, wr_n, rd_n,
		style_q, style_oe_n, input data, irq, frame_mark);
endinterface
`default_nettype wire

// *** src/host_port_host.sv ***
// Purpose: Host end driving the dual-style host bus port.
// Assumes: One request at a time from the user side.
// Notes: Each access holds its strobe low for a fixed count.
`timescale 1ns/10ps
`default_nettype none
`include "host_port_cfg.svh"
module host_port_host (
	input  wire logic                 clk_i,
	input  wire logic                 reset_i,
	host_port_if.host                 pins,
	input  wire logic                 style_i,
	input  wire logic                 style_drive_i,
	input  wire logic                 req_i,
	input  wire logic                 req_write_i,
	input  wire logic [1:0]           req_addr_i,
	input  wire host_port_pkg::word_t req_data_i,
	output logic                      busy_o,
	output logic                      done_o,
	output host_port_pkg::word_t      rdata_o,
	output logic                      irq_o,
	output logic                      frame_mark_o
);
	import host_port_pkg::*;

	host_state_e state_ff;
	logic [7:0]  cnt_ff;
	logic        wr_ff;
	logic [1:0]  addr_ff;
	word_t       wdata_ff;
	word_t       rdata_ff;
	logic        done_ff;
	word_t       data_s1_ff;
	word_t       data_s2_ff;
	logic [1:0]  in_s1_ff;
	logic [1:0]  in_s2_ff;

	wire last_cnt = (cnt_ff == 8'h00);

	// Pins from the device pass two flops before use.
	always_ff @(posedge clk_i) begin
		data_s1_ff <= pins.data;
		data_s2_ff <= data_s1_ff;
		in_s1_ff   <= {pins.irq, pins.frame_mark};
		in_s2_ff   <= in_s1_ff;
	end

	// Idle, strobe low for a fixed time, then a recovery gap.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_ff <= H_IDLE;
			cnt_ff   <= 8'h00;
			wr_ff    <= 1'b0;
			addr_ff  <= 2'h0;
			wdata_ff <= 16'h0000;
			rdata_ff <= 16'h0000;
			done_ff  <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			case (state_ff)
				H_IDLE: begin
					if (req_i) begin
						state_ff <= H_STROBE;
						cnt_ff   <= 8'(`STROBE_CYC - 1);
						wr_ff    <= req_write_i;
						addr_ff  <= req_addr_i;
						wdata_ff <= req_data_i;
					end
				end
				H_STROBE: begin
					if (last_cnt) begin
						state_ff <= H_GAP;
						cnt_ff   <= 8'(`GAP_CYC - 1);
						if (!wr_ff) begin
							rdata_ff <= data_s2_ff;
						end
					end else begin
						cnt_ff <= cnt_ff - 8'h01;
					end
				end
				H_GAP: begin
					if (last_cnt) begin
						state_ff <= H_IDLE;
						done_ff  <= 1'b1;
					end else begin
						cnt_ff <= cnt_ff - 8'h01;
					end
				end
				default: state_ff <= H_IDLE;
			endcase
		end
	end

	wire strobing = (state_ff == H_STROBE);
	wire active   = (state_ff != H_IDLE);
	// Strobe style pulses one strobe; data-strobe style sets the select.
	wire wr_pulse = strobing & (style_i ? 1'b1 : wr_ff);
	wire rd_pulse = strobing & !wr_ff & !style_i;

	// Chip select spans the whole access, like the address.
	assign pins.cs_n       = !active;
	assign pins.addr       = {1'b0, addr_ff};
	assign pins.wr_n       = !wr_pulse;
	// Select high to read, low to write, in data-strobe style.
	assign pins.rd_n       = style_i ? (active & !wr_ff) : !rd_pulse;
	// Write data is held across the strobe and through the gap.
	assign pins.host_q     = wdata_ff;
	assign pins.host_oe_n  = !(active & wr_ff);
	assign pins.style_q    = style_i;
	assign pins.style_oe_n = !style_drive_i;
	assign busy_o          = active;
	assign done_o          = done_ff;
	assign rdata_o         = rdata_ff;
	assign irq_o           = in_s2_ff[1];
	assign frame_mark_o    = in_s2_ff[0];
endmodule
`default_nettype wire

// *** sim/host_port_properties.sv ***
// Purpose: Pin-level checks of the host bus port between its two ends.
// Assumes: Both ends share clk_i and the synchronous reset_i.
// Notes: Takes the interface signals as plain inputs.
`timescale 1ns/10ps
`default_nettype none
module host_port_properties (
	input wire logic       clk_i,
	input wire logic       reset_i,
	input wire logic       dev_oe_n,
	input wire logic       host_oe_n,
	input wire logic [2:0] addr,
	input wire logic       cs_n,
	input wire logic       wr_n,
	input wire logic       rd_n,
	input wire logic       style
);
	// Read request as the device should see it, per strobe style.
	wire rd_cond = style ? (rd_n & !wr_n) : (!cs_n & !rd_n);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	// The two phases of one host access.
	sequence strobe_low_s;
		!wr_n[*8];
	endsequence
	sequence strobe_high_s;
		wr_n[*4];
	endsequence

	////////////////////////////////////////////////////////////////////////////////
	// Five idle samples leave room for the two sync flops and the enable flop.
	bus_release_a: assert property ((!rd_cond)[*5] |-> dev_oe_n)
		else $error("device drives the bus with no read");
	read_drive_a: assert property (rd_cond[*5] |-> !dev_oe_n)
		else $error("device silent during a read");
	no_fight_a: assert property (dev_oe_n || host_oe_n)
		else $error("both ends drive the data bus");
	strobe_width_a: assert property ($fell(wr_n) |-> strobe_low_s)
		else $error("strobe low too short");
	strobe_gap_a: assert property ($rose(wr_n) |-> strobe_high_s)
		else $error("strobe high too short");
	addr_stable_a: assert property ($fell(wr_n) |=> ($stable(addr) && $stable(cs_n))[*7])
		else $error("address moved under the strobe");
	cs_qualify_a: assert property (!style && (!wr_n || !rd_n) |-> !cs_n)
		else $error("strobe without chip select");
	rw_select_a: assert property (style && !wr_n |-> rd_n == host_oe_n)
		else $error("select level disagrees with direction");
endmodule
`default_nettype wire

// *** sim/host_port_dual_style_tb.sv ***
// Purpose: Self-checking bench joining both ends of the host bus port.
// Assumes: The host end's user side is the only way onto the bus.
// Notes: Both strobe styles are run; style 0 leaves the style pin undriven.
`timescale 1ns/10ps
`default_nettype none
`include "host_port_cfg.svh"
module host_bus_port_dual_style_tb;
	import host_port_pkg::*;
	logic       clk_i = 1'b0;
	logic       reset_i = 1'b1;
	logic       style_i = 1'b0;
	logic       style_drive_i = 1'b0;
	logic       req_i = 1'b0;
	logic       req_write_i = 1'b0;
	logic [1:0] req_addr_i = 2'h0;
	word_t      req_data_i = 16'h0000;
	word_t      sample_i = 16'h0000;
	logic       sample_valid_i = 1'b0;
	logic       word_start_i = 1'b0;
	logic       frame_start_i = 1'b0;
	word_t      rdata_o;
	logic [15:0] mark_cfg_o;
	logic [15:0] irq_len_o;
	logic       done_o;
	logic       busy_o;
	logic       irq_o;
	logic       frame_mark_o;
	int         err_total = 0;
	int         num_checks = 0;

	host_port_if bus ();
	host_port_dev #(.IRQ_CNT_W(16)) host_port_dev_inst (.clk_i, .reset_i, .pins(bus.device),
		.sample_i, .sample_valid_i, .word_start_i, .frame_start_i, .mark_cfg_o, .irq_len_o);
	host_port_host host_port_host_inst (.clk_i, .reset_i, .pins(bus.host), .style_i,
		.style_drive_i, .req_i, .req_write_i, .req_addr_i, .req_data_i, .busy_o,
		.done_o, .rdata_o, .irq_o, .frame_mark_o);
	host_port_properties host_port_properties_inst (.clk_i(clk_i), .reset_i(reset_i),
		.dev_oe_n(bus.dev_oe_n), .host_oe_n(bus.host_oe_n), .addr(bus.addr),
		.cs_n(bus.cs_n), .wr_n(bus.wr_n), .rd_n(bus.rd_n), .style(bus.style));

	// Half period of 2 ns gives 250 MHz.
	always #2 clk_i = !clk_i;

	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp_w(input word_t got, input word_t exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One host access; waits for done under a bound so a hang is counted.
	task automatic access(input logic w, input logic [1:0] a, input word_t d);
		int k;
		@(posedge clk_i);
		{req_i, req_write_i, req_addr_i, req_data_i} <= {1'b1, w, a, d};
		@(posedge clk_i);
		req_i <= 1'b0;
		k = 0;
		#1;
		cmp_w({15'h0000, busy_o}, 16'h0001);
		while (done_o !== 1'b1 && k < 40) begin
			@(posedge clk_i);
			#1;
			k++;
		end
		if (k == 40) err_total++;
	endtask

	task automatic rd(input logic [1:0] a, input word_t e);
		access(1'b0, a, 16'h0000);
		cmp_w(rdata_o, e);
	endtask

	// Pulses device events p = {sample, word, frame}; counts output cycles at lvl.
	task automatic pulse(input logic [2:0] p, input logic lvl, input word_t e);
		int c;
		@(posedge clk_i);
		{sample_valid_i, word_start_i, frame_start_i} <= p;
		@(posedge clk_i);
		{sample_valid_i, word_start_i, frame_start_i} <= 3'h0;
		c = 0;
		repeat (20) begin
			@(posedge clk_i);
			#1;
			c += ((p[2] ? irq_o : frame_mark_o) === lvl);
		end
		cmp_w(c[15:0], e);
	endtask

	task automatic summarize();
		if (err_total == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// The run needs well under 1500 cycles, so 4000 means a hang.
	initial begin
		repeat (4000) @(posedge clk_i);
		err_total++;
		summarize();
	end

	initial begin
		repeat (5) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		#1;
		cmp_w(mark_cfg_o, `MARK_CFG_RST);
		cmp_w(irq_len_o, `IRQ_LEN_RST);
		pulse(3'h1, 1'b1, 16'h0001);
		pulse(3'h2, 1'b1, 16'h0000);
		for (int s = 0; s < 2; s++) begin
			@(posedge clk_i);
			{style_i, style_drive_i, sample_i} <= {s[0], s[0], 16'hA5C3 ^ word_t'(s)};
			access(1'b1, `ADDR_HOLD, 16'h8001 | word_t'(s));
			rd(`ADDR_HOLD, 16'h8001 | word_t'(s));
			access(1'b1, `ADDR_HOLD, 16'h0002 | word_t'(s));
			access(1'b1, `ADDR_IRQ_LEN, 16'h0000);
			cmp_w(irq_len_o, 16'h0002 | word_t'(s));
			access(1'b1, `ADDR_SAMPLE, 16'h0000);
			pulse(3'h4, 1'b1, 16'h0002 | word_t'(s));
			rd(`ADDR_SAMPLE, 16'hA5C3 ^ word_t'(s));
		end
		// Active-low mark on word starts only, then a zero-length interrupt.
		access(1'b1, `ADDR_HOLD, 16'h0002);
		access(1'b1, `ADDR_MARK_CFG, 16'h0000);
		cmp_w(mark_cfg_o, 16'h0002);
		pulse(3'h2, 1'b0, 16'h0001);
		pulse(3'h1, 1'b0, 16'h0000);
		access(1'b1, `ADDR_HOLD, 16'h0000);
		access(1'b1, `ADDR_IRQ_LEN, 16'h0000);
		pulse(3'h4, 1'b1, 16'h0000);
		summarize();
	end
endmodule
`default_nettype wire
